// >>> core/dfs_pkg.sv
// package for the drive fault supervisor: register map, field codes, timing
// assumes a 25 MHz system clock and 32-bit apb registers
package dfs_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int RESTART_RUN_MIN = 10;
   localparam int RESTART_RUN_MS = RESTART_RUN_MIN * 60 * 1000;
   // register byte offsets
   localparam logic [7:0] REG_LOSS_CFG = 8'h00;
   localparam logic [7:0] REG_RESTART_CFG = 8'h04;
   localparam logic [7:0] REG_TORQUE_CFG = 8'h08;
   localparam logic [7:0] REG_OUT_CFG = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_CONTROL = 8'h14;
   // loss config: [0] response sel, [10:1] fallback pct x10, [19:11] window ms
   localparam logic [31:0] LOSS_CFG_RST = 32'h0000_A640;
   // restart cfg: [3:0] limit, [4] fault out en, [17:5] interval x100 ms
   localparam logic [31:0] RESTART_CFG_RST = 32'h0000_0C80;
   // torque cfg: [3:0] sel, [12:4] level pct, [19:13] time x100 ms
   localparam logic [31:0] TORQUE_CFG_RST = 32'h0000_2960;
   localparam logic [9:0] LOSS_WIN_MIN = 10'h014;
   localparam logic [9:0] LOSS_WIN_MAX = 10'h190;
   localparam logic [9:0] PCT_FULL = 10'h3E8;
   localparam logic [3:0] LIMIT_MAX = 4'hA;
   localparam logic [12:0] INTERVAL_MIN = 13'h0005;
   localparam logic [12:0] INTERVAL_MAX = 13'h1770;
   localparam logic [8:0] LEVEL_MAX = 9'h12C;
   localparam logic [6:0] TQ_TIME_MAX = 7'h64;
   localparam logic [8:0] HYST_PCT = 9'h00A;
   // multi-function output codes
   localparam logic [4:0] MO_LOSS = 5'h09;
   localparam logic [4:0] MO_FAULT = 5'h0B;
   localparam logic [4:0] MO_RESTART = 5'h0E;
   localparam logic [4:0] MO_TQ1 = 5'h12;
   localparam logic [4:0] MO_TQ2 = 5'h14;
   localparam int NUM_MO = 4;
   // restart sequencer states
   typedef enum logic [2:0] {
      DFS_IDLE = 3'b000,
      DFS_DIAG = 3'b001,
      DFS_WAIT = 3'b010,
      DFS_SEARCH = 3'b011,
      DFS_LOCK = 3'b100
   } dfs_state_t;
endpackage

// >>> core/dfs_top.sv
// drive fault supervisor: command loss, fault restart, torque detection
// assumes apb master on clk; drive-side inputs come from other clock domains
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
module dfs_top
   import dfs_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int RUN_OK_MS = RESTART_RUN_MS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] freq_cmd_in,
   input wire logic [15:0] max_output_freq,
   input wire logic [15:0] motor2_max_output_freq,
   input wire logic motor2_sel,
   input wire logic run_cmd_in,
   input wire logic speed_agree,
   input wire logic vector_mode,
   input wire logic [8:0] current_pct,
   input wire logic [8:0] torque_pct,
   input wire logic [13:0] fault_vec,
   input wire logic other_fault,
   input wire logic diag_ok,
   input wire logic search_done,
   output logic [15:0] freq_cmd_out,
   output logic run_cmd_out,
   output logic speed_search_req,
   output logic drive_stop,
   output logic [NUM_MO-1:0] multi_out
);
   // fault_vec: ground fault, overvoltage and overcurrent in accel, decel
   // and constant speed, heatsink, motor and drive overload, both overload
   // detections, input and output phase loss; any set bit is eligible
   typedef struct packed {
      logic [31:0] loss_cfg;
      logic [31:0] restart_cfg;
      logic [31:0] torque_cfg;
      logic [19:0] out_cfg;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic [14:0] tick_cnt;
      logic tick;
      logic [15:0] prev_cmd;
      logic [8:0] loss_ms;
      logic loss;
      dfs_state_t st;
      logic [3:0] attempts;
      logic [19:0] wait_ms;
      logic [19:0] ok_ms;
      logic restarted;
      logic [13:0] tq_ms;
      logic tq_event;
      logic tq_fault;
      logic [15:0] freq_out;
      logic [NUM_MO-1:0] mo;
   } dfs_state_s_t;
   dfs_state_s_t q, d;
   logic [1:0] s_run, s_agree, s_mode, s_diag, s_srch, s_oth, s_m2;
   logic [13:0] s_fv1, s_fv2;
   logic [15:0] s_cmd1, s_cmd2, s_mx1, s_mx2, s_mx21, s_mx22;
   logic [8:0] s_cu1, s_cu2, s_tq1, s_tq2;
   logic man_reset;
   logic [1:0] rst_sync_q;
   logic rst_n_i;

   // release reset through two flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n_i = rst_sync_q[1];

   // drive-side inputs cross in from other domains; only stage two is read
   always_ff @(posedge clk) begin
      s_run <= {s_run[0], run_cmd_in};
      s_agree <= {s_agree[0], speed_agree};
      s_mode <= {s_mode[0], vector_mode};
      s_diag <= {s_diag[0], diag_ok};
      s_srch <= {s_srch[0], search_done};
      s_oth <= {s_oth[0], other_fault};
      s_m2 <= {s_m2[0], motor2_sel};
      s_fv1 <= fault_vec;
      s_fv2 <= s_fv1;
      s_cmd1 <= freq_cmd_in;
      s_cmd2 <= s_cmd1;
      s_mx1 <= max_output_freq;
      s_mx2 <= s_mx1;
      s_mx21 <= motor2_max_output_freq;
      s_mx22 <= s_mx21;
      s_cu1 <= current_pct;
      s_cu2 <= s_cu1;
      s_tq1 <= torque_pct;
      s_tq2 <= s_tq1;
   end

   // scale a frequency by a tenth-percent figure
   function automatic logic [15:0] pct_of(input logic [15:0] f,
                                          input logic [9:0] p);
      logic [25:0] prod;
      prod = 26'(f) * 26'(p);
      pct_of = 16'(prod / 26'(PCT_FULL));
   endfunction

   // clamp a field into its allowed range
   function automatic logic [12:0] clamp(input logic [12:0] v,
                                         input logic [12:0] lo,
                                         input logic [12:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   logic resp_sel, fout_en, run_s, agree_s, diag_s, srch_s;
   logic [9:0] fb_pct;
   logic [12:0] win_ms, lim, ivl, lvl, tq_time;
   logic [8:0] meas;
   logic eligible, over, under, in_band, mon, tq_over_mode;
   logic [3:0] tsel;
   logic wr;
   logic [31:0] status;

   always_comb begin
      resp_sel = q.loss_cfg[0];
      fb_pct = 10'(clamp(13'(q.loss_cfg[10:1]), 13'h0000, 13'(PCT_FULL)));
      win_ms = clamp(13'(q.loss_cfg[19:11]), 13'(LOSS_WIN_MIN),
                     13'(LOSS_WIN_MAX));
      lim = clamp(13'(q.restart_cfg[3:0]), 13'h0000, 13'(LIMIT_MAX));
      fout_en = q.restart_cfg[4];
      ivl = clamp(q.restart_cfg[17:5], INTERVAL_MIN, INTERVAL_MAX);
      tsel = q.torque_cfg[3:0];
      lvl = clamp(13'(q.torque_cfg[12:4]), 13'h0000, 13'(LEVEL_MAX));
      tq_time = clamp(13'(q.torque_cfg[19:13]), 13'h0000,
                      13'(TQ_TIME_MAX));
      run_s = s_run[1];
      agree_s = s_agree[1];
      diag_s = s_diag[1];
      srch_s = s_srch[1];
      // level refers to torque in vector methods, current otherwise
      meas = s_mode[1] ? s_tq2 : s_cu2;
      eligible = |s_fv2;
      wr = psel && penable && pwrite;
      man_reset = wr && (paddr == REG_CONTROL) && pwdata[0];
      status = {20'h0_0000, q.tq_fault, q.tq_event, q.attempts,
                q.st, 1'b0, q.restarted, q.loss};
   end

   // main next-state logic
   always_comb begin
      d = q;
      d.pready = psel && !penable;
      d.pslverr = 1'b0;
      // apb register access; unmapped reads return zero with slverr
      if (psel && !penable) begin
         d.prdata = 32'h0000_0000;
         case (paddr)
            REG_LOSS_CFG: d.prdata = q.loss_cfg;
            REG_RESTART_CFG: d.prdata = q.restart_cfg;
            REG_TORQUE_CFG: d.prdata = q.torque_cfg;
            REG_OUT_CFG: d.prdata = 32'(q.out_cfg);
            REG_STATUS: d.prdata = status;
            REG_CONTROL: d.prdata = 32'h0000_0000;
            default: d.pslverr = 1'b1;
         endcase
      end
      if (wr) begin
         case (paddr)
            REG_LOSS_CFG: d.loss_cfg = pwdata;
            REG_RESTART_CFG: d.restart_cfg = pwdata;
            REG_TORQUE_CFG: d.torque_cfg = pwdata;
            REG_OUT_CFG: d.out_cfg = pwdata[19:0];
            default: d.out_cfg = q.out_cfg;
         endcase
      end
      // millisecond tick shared by every timer
      d.tick = 1'b0;
      if (q.tick_cnt == 15'(TICK_CYCLES - 1)) begin
         d.tick_cnt = 15'h0000;
         d.tick = 1'b1;
      end else begin
         d.tick_cnt = q.tick_cnt + 15'h0001;
      end
      // command loss: drop below 90% of the value seen a window ago; the
      // reference is frozen during a loss so only a real restore clears it
      if (q.tick) begin
         if (q.loss_ms + 9'h001 >= 9'(win_ms)) begin
            d.loss_ms = 9'h000;
            if (!q.loss) begin
               if (32'(s_cmd2) * 32'd10 < 32'(q.prev_cmd) * 32'd9) begin
                  d.loss = 1'b1;
               end else begin
                  d.prev_cmd = s_cmd2;
               end
            end else if (32'(s_cmd2) * 32'd10 >=
                         32'(q.prev_cmd) * 32'd9) begin
               d.prev_cmd = s_cmd2;
               d.loss = 1'b0;
            end
         end else begin
            d.loss_ms = q.loss_ms + 9'h001;
         end
      end
      // substitute fallback only with selection 1
      if (q.loss && resp_sel) begin
         d.freq_out = pct_of(s_m2[1] ? s_mx22 : s_mx2, fb_pct);
      end else begin
         d.freq_out = s_cmd2;
      end
      // torque detection with hysteresis and qualifying time
      tq_over_mode = (tsel >= 4'h1) && (tsel <= 4'h4);
      mon = (tsel != 4'h0) && (tsel <= 4'h8) && run_s &&
            (tsel[0] ? agree_s : 1'b1);
      over = 13'(meas) > lvl;
      under = 13'(meas) < lvl;
      in_band = tq_over_mode ? (13'(meas) + 13'(HYST_PCT) > lvl)
                             : (13'(meas) < lvl + 13'(HYST_PCT));
      if (!mon) begin
         d.tq_ms = 14'h0000;
         d.tq_event = 1'b0;
      end else if (tq_over_mode ? over : under) begin
         if (q.tick && q.tq_ms <= 14'(tq_time) * 14'd100) begin
            d.tq_ms = q.tq_ms + 14'h0001;
         end
         if (q.tq_ms > 14'(tq_time) * 14'd100) begin
            d.tq_event = 1'b1;
         end
      end else begin
         d.tq_ms = 14'h0000;
         if (!in_band) begin
            d.tq_event = 1'b0;
         end
      end
      // fault selections 3,4,7,8 stop the drive until manual reset
      if (q.tq_event && ((tsel == 4'h3) || (tsel == 4'h4) ||
                         (tsel == 4'h7) || (tsel == 4'h8))) begin
         d.tq_fault = 1'b1;
      end else if (man_reset) begin
         d.tq_fault = 1'b0;
      end
      // restart sequencer
      case (q.st)
         DFS_IDLE: begin
            if (q.restarted && run_s && q.tick) begin
               d.ok_ms = q.ok_ms + 20'h0_0001;
               if (q.ok_ms + 20'h0_0001 >= 20'(RUN_OK_MS)) begin
                  d.attempts = 4'h0;
                  d.restarted = 1'b0;
                  d.ok_ms = 20'h0_0000;
               end
            end
            if (s_oth[1]) begin
               d.st = DFS_LOCK;
            end else if (eligible && run_s) begin
               d.ok_ms = 20'h0_0000;
               d.wait_ms = 20'h0_0000;
               d.st = (13'(q.attempts) >= lim) ? DFS_LOCK : DFS_DIAG;
            end
         end
         DFS_DIAG: begin
            if (q.tick) begin
               d.wait_ms = q.wait_ms + 20'h0_0001;
            end
            if (q.wait_ms >= 20'(ivl) * 20'd100) begin
               d.st = DFS_WAIT;
            end
         end
         DFS_WAIT: begin
            if (diag_s && !eligible) begin
               d.attempts = q.attempts + 4'h1;
               d.st = DFS_SEARCH;
            end
         end
         DFS_SEARCH: begin
            if (srch_s) begin
               d.restarted = 1'b1;
               d.st = DFS_IDLE;
            end
         end
         DFS_LOCK: begin
            d.st = DFS_LOCK;
         end
         default: d.st = DFS_IDLE;
      endcase
      if (man_reset) begin
         d.attempts = 4'h0;
         d.restarted = 1'b0;
         d.st = DFS_IDLE;
      end
      // multi-function outputs
      for (int i = 0; i < NUM_MO; i++) begin
         case (q.out_cfg[i*5 +: 5])
            MO_LOSS: d.mo[i] = q.loss;
            MO_RESTART: d.mo[i] = (q.st == DFS_DIAG) || (q.st == DFS_WAIT) ||
                                  (q.st == DFS_SEARCH);
            MO_FAULT: d.mo[i] = (q.st == DFS_LOCK) || q.tq_fault ||
                                (fout_en && q.st != DFS_IDLE);
            MO_TQ1: d.mo[i] = q.tq_event;
            MO_TQ2: d.mo[i] = 1'b0;   // channel 2 not instanced
            default: d.mo[i] = 1'b0;
         endcase
      end
   end

   // state register; reset clears counters and latched flags
   always_ff @(posedge clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q.loss_cfg <= LOSS_CFG_RST;
         q.restart_cfg <= RESTART_CFG_RST;
         q.torque_cfg <= TORQUE_CFG_RST;
         q.out_cfg <= 20'h0_0000;
         q.pready <= 1'b0;
         q.prdata <= 32'h0000_0000;
         q.pslverr <= 1'b0;
         q.tick_cnt <= 15'h0000;
         q.tick <= 1'b0;
         q.prev_cmd <= 16'h0000;
         q.loss_ms <= 9'h000;
         q.loss <= 1'b0;
         q.st <= DFS_IDLE;
         q.attempts <= 4'h0;
         q.wait_ms <= 20'h0_0000;
         q.ok_ms <= 20'h0_0000;
         q.restarted <= 1'b0;
         q.tq_ms <= 14'h0000;
         q.tq_event <= 1'b0;
         q.tq_fault <= 1'b0;
         q.freq_out <= 16'h0000;
         q.mo <= '0;
      end else begin
         q <= d;
      end
   end

   // run command is dropped while a fault sequence is active
   assign run_cmd_out = run_s && (q.st == DFS_IDLE) && !q.tq_fault;
   assign speed_search_req = (q.st == DFS_SEARCH);
   assign drive_stop = (q.st == DFS_LOCK) || q.tq_fault;
   assign freq_cmd_out = q.freq_out;
   assign multi_out = q.mo;
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;

   // a manual reset returns the attempt count to zero next cycle
   attempt_clear_a: assert property (@(posedge clk) disable iff (!rst_n_i)
      man_reset |=> q.attempts == 4'h0) else $error("attempts not cleared");
   lock_limit_a: assert property (@(posedge clk) disable iff (!rst_n_i)
      (q.st == DFS_IDLE && eligible && run_s && !s_oth[1] && !man_reset &&
       13'(q.attempts) >= lim) |=> q.st == DFS_LOCK)
      else $error("limit not enforced");
   run_drop_a: assert property (@(posedge clk) disable iff (!rst_n_i)
      (q.st != DFS_IDLE) |-> !run_cmd_out) else $error("run not dropped");
   restart_gate_a: assert property (@(posedge clk) disable iff (!rst_n_i)
      (q.st == DFS_WAIT && !diag_s) |=> q.st != DFS_SEARCH)
      else $error("restart without diagnosis");
   fallback_off_a: assert property (@(posedge clk) disable iff (!rst_n_i)
      (!resp_sel && !q.loss) |=> freq_cmd_out == $past(s_cmd2))
      else $error("command not followed");
   torque_off_a: assert property (@(posedge clk) disable iff (!rst_n_i)
      (tsel == 4'h0) |=> !q.tq_event) else $error("detect when disabled");
   torque_qual_a: assert property (@(posedge clk) disable iff (!rst_n_i)
      $rose(q.tq_event) |-> $past(q.tq_ms) > 14'(tq_time) * 14'd100)
      else $error("event before time");
   search_req_a: assert property (@(posedge clk) disable iff (!rst_n_i)
      (q.st == DFS_WAIT && diag_s && !eligible && !man_reset) |=>
      speed_search_req) else $error("no speed search");
endmodule

// >>> verification/dfs_drive_model.sv
// behavioural drive power stage that answers speed search requests
// assumes levels sampled on clk; the bench sets how slow the search is
`timescale 1ns/1ps
module dfs_drive_model (
   input wire logic clk,
   input wire logic speed_search_req,
   input wire logic [7:0] search_delay,
   output logic search_done
);
   int cnt = 0;

   initial search_done = 1'b0;

   // search completes after the set delay and holds while still requested;
   // a dropped request clears it at once so no stale done can leak through
   always @(posedge clk) begin
      if (!speed_search_req) begin
         cnt <= 0;
         search_done <= 1'b0;
      end else if (cnt >= search_delay) begin
         search_done <= 1'b1;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

// >>> verification/drive_fault_supervisor_tb_top.sv
// self-checking bench for the drive fault supervisor
// assumes dfs_pkg and dfs_top are compiled first; 1 ms tick is 4 clocks
`timescale 1ns/1ps
module drive_fault_supervisor_tb_top;
   import dfs_pkg::*;
   localparam int TK = 4;
   localparam int LIMIT = 60000;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic [15:0] freq_cmd_in = 16'h0000;
   logic [15:0] max_output_freq = 16'h1388;
   logic [15:0] motor2_max_output_freq = 16'h09C4;
   logic motor2_sel = 1'b0, run_cmd_in = 1'b0, speed_agree = 1'b0;
   logic vector_mode = 1'b0, other_fault = 1'b0, diag_ok = 1'b1;
   logic [8:0] current_pct = 9'h096, torque_pct = 9'h096;
   logic [13:0] fault_vec = 14'h0000;
   logic search_done, run_cmd_out, speed_search_req, drive_stop;
   logic [15:0] freq_cmd_out;
   logic [NUM_MO-1:0] multi_out;
   logic [7:0] search_delay = 8'h02;
   int seed = 84714;
   int checks = 0, miscompares = 0, cycles = 0;

   always #20 clk = ~clk;

   dfs_top #(.TICK_CYCLES(TK), .RUN_OK_MS(20)) i_dfs_top (
      .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .freq_cmd_in(freq_cmd_in),
      .max_output_freq(max_output_freq),
      .motor2_max_output_freq(motor2_max_output_freq),
      .motor2_sel(motor2_sel), .run_cmd_in(run_cmd_in),
      .speed_agree(speed_agree), .vector_mode(vector_mode),
      .current_pct(current_pct), .torque_pct(torque_pct),
      .fault_vec(fault_vec), .other_fault(other_fault), .diag_ok(diag_ok),
      .search_done(search_done), .freq_cmd_out(freq_cmd_out),
      .run_cmd_out(run_cmd_out), .speed_search_req(speed_search_req),
      .drive_stop(drive_stop), .multi_out(multi_out));

   dfs_drive_model i_dfs_drive_model (.clk(clk),
      .speed_search_req(speed_search_req), .search_delay(search_delay),
      .search_done(search_done));

   task automatic end_of_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // a hang would otherwise stall the run forever
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // apb master: request held until pready is sampled high
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // only the bench timeout ends a wait for pready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk("wr_err", 0, e);
   endtask

   task automatic rd(logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk("rd_err", 0, e);
   endtask

   function automatic logic sig(int s);
      case (s)
         4: return speed_search_req;
         5: return drive_stop;
         6: return run_cmd_out;
         default: return multi_out[s];
      endcase
   endfunction

   // bounded wait; n equals mx when the level never showed
   task automatic wait_sig(int s, logic v, int mx, output int n);
      n = 0;
      while (sig(s) !== v && n < mx) begin
         @(posedge clk);
         n++;
      end
   endtask

   function automatic logic [15:0] exp_fb(int pct, int mx);
      return 16'(mx * pct / 1000);
   endfunction

   function automatic logic [31:0] loss_cfg(int s, int fb, int win);
      return 32'((win << 11) | (fb << 1) | s);
   endfunction

   function automatic logic [31:0] rs_cfg(int lim, int en, int iv);
      return 32'((iv << 5) | (en << 4) | lim);
   endfunction

   // one eligible fault, then diagnosis and speed search restart
   task automatic restart_once(logic en, logic late);
      int n;
      fault_vec <= 14'(1 << ($unsigned($random(seed)) % 14));
      diag_ok <= 1'b0;
      wait_sig(6, 1'b0, 10, n);
      chk("run_removed", 0, run_cmd_out);
      wait_sig(1, 1'b1, 10, n);
      repeat (2) @(posedge clk);
      chk("restart_out", 1, multi_out[1]);
      chk("fault_out", en, multi_out[3]);
      fault_vec <= 14'h0000;
      if (late) begin
         wait_sig(4, 1'b1, 2600, n);
         chk("search_early", 2600, n);
      end
      diag_ok <= 1'b1;
      wait_sig(4, 1'b1, 2600, n);
      if (!late) chk("interval", 1, n >= 1890 && n <= 2100);
      chk("search_req", 1, speed_search_req);
      wait_sig(4, 1'b0, 300, n);
      wait_sig(6, 1'b1, 20, n);
      chk("run_back", 1, run_cmd_out);
   endtask

   initial begin
      int n;
      logic [31:0] r;
      logic e;
      logic [15:0] base;
      logic under, flt;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd(REG_LOSS_CFG, r);
      chk("loss_rst", LOSS_CFG_RST, r);
      rd(REG_RESTART_CFG, r);
      chk("rs_rst", RESTART_CFG_RST, r);
      rd(REG_TORQUE_CFG, r);
      chk("tq_rst", TORQUE_CFG_RST, r);
      apb(1'b0, 8'h20, 32'h0000_0000, r, e);
      chk("unmapped_err", 1, e);
      chk("unmapped_data", 0, r);
      wr(REG_OUT_CFG, {12'h000, MO_FAULT, MO_TQ1, MO_RESTART, MO_LOSS});
      wr(REG_LOSS_CFG, loss_cfg(1, 800, 20));
      base = 16'(2000 + ($unsigned($random(seed)) % 4000));
      freq_cmd_in <= base;
      repeat (200) @(posedge clk);
      // a slow fall of 4% per step spaced beyond the window is no loss
      for (int i = 0; i < 6; i++) begin
         freq_cmd_in <= 16'(freq_cmd_in * 24 / 25);
         wait_sig(0, 1'b1, 120, n);
         chk("slow_ramp", 120, n);
      end
      freq_cmd_in <= 16'(freq_cmd_in / 2);
      wait_sig(0, 1'b1, 200, n);
      chk("loss_flag", 1, multi_out[0]);
      repeat (3) @(posedge clk);
      chk("fallback", exp_fb(800, 5000), freq_cmd_out);
      motor2_sel <= 1'b1;
      repeat (6) @(posedge clk);
      chk("fallback_m2", exp_fb(800, 2500), freq_cmd_out);
      // a low command that stays low is still a loss after a window
      repeat (100) @(posedge clk);
      chk("loss_held", 1, multi_out[0]);
      freq_cmd_in <= base;
      wait_sig(0, 1'b0, 200, n);
      repeat (3) @(posedge clk);
      chk("restored", base, freq_cmd_out);
      wr(REG_LOSS_CFG, loss_cfg(0, 800, 20));
      repeat (200) @(posedge clk);
      freq_cmd_in <= base / 2;
      wait_sig(0, 1'b1, 200, n);
      repeat (3) @(posedge clk);
      chk("no_fallback", base / 2, freq_cmd_out);
      freq_cmd_in <= base;
      run_cmd_in <= 1'b1;
      // every torque selection, measured on the quantity its mode names
      for (int s = 1; s <= 8; s++) begin
         under = s > 4;
         flt = s inside {3, 4, 7, 8};
         vector_mode <= s > 4;
         current_pct <= (s > 4) == under ? 9'h0C8 : 9'h028;
         torque_pct <= (s > 4) == under ? 9'h028 : 9'h0C8;
         speed_agree <= 1'b0;
         wr(REG_TORQUE_CFG, 32'((1 << 13) | (150 << 4) | s));
         if (s % 2) begin
            wait_sig(2, 1'b1, 600, n);
            chk("no_agree", 600, n);
            speed_agree <= 1'b1;
         end
         wait_sig(2, 1'b1, 600, n);
         chk("detect_time", 1, n >= 360 && n <= 480);
         repeat (3) @(posedge clk);
         chk("tq_stop", flt, drive_stop);
         chk("tq_run", !flt, run_cmd_out);
         if (s == 2) begin
            current_pct <= 9'h091;
            wait_sig(2, 1'b0, 100, n);
            chk("hyst_hold", 100, n);
            current_pct <= 9'h082;
            wait_sig(2, 1'b0, 600, n);
            chk("hyst_drop", 0, multi_out[2]);
         end
         wr(REG_TORQUE_CFG, 32'h0000_2000);
         wr(REG_CONTROL, 32'h0000_0001);
         current_pct <= 9'h096;
         torque_pct <= 9'h096;
         repeat (20) @(posedge clk);
      end
      vector_mode <= 1'b0;
      wr(REG_RESTART_CFG, rs_cfg(2, 0, 5));
      repeat (20) @(posedge clk);
      restart_once(1'b0, 1'b0);
      rd(REG_STATUS, r);
      chk("attempts_one", 1, r[9:6]);
      repeat (150) @(posedge clk);
      rd(REG_STATUS, r);
      chk("attempts_aged", 0, r[9:6]);
      wr(REG_RESTART_CFG, rs_cfg(2, 1, 5));
      search_delay <= 8'h3C;
      restart_once(1'b1, 1'b1);
      restart_once(1'b1, 1'b0);
      fault_vec <= 14'h0001;
      wait_sig(5, 1'b1, 20, n);
      chk("lockout", 1, drive_stop);
      fault_vec <= 14'h0000;
      rd(REG_STATUS, r);
      chk("lock_state", DFS_LOCK, r[5:3]);
      wr(REG_CONTROL, 32'h0000_0001);
      rd(REG_STATUS, r);
      chk("attempts_clr", 0, r[9:6]);
      other_fault <= 1'b1;
      wait_sig(5, 1'b1, 20, n);
      chk("other_lock", 1, drive_stop);
      chk("other_no_rs", 0, multi_out[1]);
      other_fault <= 1'b0;
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk("rst_out", 0, multi_out);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd(REG_STATUS, r);
      chk("rst_status", 0, r[9:6]);
      end_of_test();
   end
endmodule
